// *** dv/ionizer_mode_controller_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module ionizer_mode_controller_tb;
  import ionizer_pkg::*;
  localparam int TC = 4;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fan_auto_sel, h;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [2:0] mode_sel, run_mode;
  logic [1:0] fan_tap_sel, fan_tap, bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, ion_cmd, onoff_cmd, off_timer_cmd;
  logic forced_sw_cmd, supply_ok, ion_fb_ok, hv_enable, fan_request, fan_auto;
  logic vane_cool_rules, ion_led, power_led, irq, ce;
  logic [3:0] ws = 4'hf;
  int error_cnt = 0;
  int comparisons = 0;
  int st = 0;
  int n, k;
  int nx[4][4] = '{'{1, 0, 3, 2}, '{2, 3, 0, 0}, '{0, 0, 0, 0}, '{0, 1, 2, 3}};
  // clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  ionizer_mode_controller #(.TICK_CYCLES_P(TC)) ionizer_mode_controller_inst (.aclk, .aresetn,
    .ce, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .ion_cmd, .onoff_cmd,
    .off_timer_cmd, .forced_sw_cmd, .mode_sel, .fan_auto_sel, .fan_tap_sel, .supply_ok,
    .ion_fb_ok, .hv_enable, .fan_request, .fan_auto, .fan_tap, .vane_cool_rules, .run_mode,
    .ion_led, .power_led, .irq);
  remote_model rm (.aclk, .ion_cmd, .onoff_cmd, .off_timer_cmd, .forced_sw_cmd, .supply_ok,
    .ion_fb_ok);
  // compare and count
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // bus write: both channels offered together, each released when taken
  task wr(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    n = 0;
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata <= v;
    wstrb <= ws;
    do begin
      @(negedge aclk);
      {ta, tw, tb, r} = {awready, wready, bvalid, bresp};
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end while (!tb && n < 50);
    bready <= 1'b0;
    chk(tb, 1'b1);
  endtask
  // bus read
  task rd(input logic [3:0] a);
    logic ta, tv;
    n = 0;
    @(posedge aclk);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    do begin
      @(negedge aclk);
      {ta, tv, d, r} = {arready, rvalid, rdata, rresp};
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      n++;
    end while (!tv && n < 50);
    rready <= 1'b0;
    chk(tv, 1'b1);
  endtask
  // compare drives and reported state with the model state
  task look;
    @(negedge aclk);
    chk({hv_enable, ion_led, power_led}, {st[0], st[0], st[1]});
    if (st == 1) chk({fan_request, fan_auto, fan_tap}, {1'b1, fan_auto_sel, fan_tap_sel});
    if (st >= 2) chk(run_mode, mode_sel);
    rd(STATUS_OFS);
    chk(d[1:0], st);
  endtask
  // press a key with fresh random selections
  task go(input int key);
    @(posedge aclk);
    mode_sel <= 3'($urandom_range(0, 3));
    fan_auto_sel <= 1'($urandom);
    fan_tap_sel <= 2'($urandom);
    rm.press(key);
    st = nx[key][st];
    look();
  endtask
  task hv_wait(input logic v, input int lim);
    n = 0;
    while (hv_enable !== v && n < lim) begin
      @(negedge aclk);
      n++;
    end
  endtask
  // mains loss and return
  task drop;
    rm.mains(1'b0);
    repeat (5) @(negedge aclk);
    chk({hv_enable, fan_request, power_led}, 3'h0);
    rm.mains(1'b1);
    repeat (6) @(negedge aclk);
    look();
  endtask
  task tally_and_finish;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (90000) @(posedge aclk);
    error_cnt++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fan_auto_sel} = '0;
    ce = 1'b1;
    {awaddr, araddr, wstrb, wdata, mode_sel, fan_tap_sel} = '0;
    void'($urandom(82));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(negedge aclk);
    rd(CTRL_OFS);
    chk({r, d}, {RESP_OKAY, 32'h1});
    rd(4'h2);
    chk(r, RESP_SLVERR);
    // unmapped write refused, write with byte 0 strobe low has no effect
    wr(4'h2, 32'h0);
    chk(r, RESP_SLVERR);
    ws = 4'he;
    wr(CTRL_OFS, 32'h0);
    chk(r, RESP_OKAY);
    ws = 4'hf;
    rd(CTRL_OFS);
    chk(d, 32'h1);
    rd(IRQ_MASK_OFS);
    chk(d, 32'h0);
    wr(IRQ_MASK_OFS, 32'h1);
    go(0);
    rd(IRQ_STAT_OFS);
    chk({irq, d}, {1'b1, 32'h1});
    wr(IRQ_STAT_OFS, 32'h1);
    go(0);
    rd(IRQ_STAT_OFS);
    chk({irq, d}, {1'b0, 32'h2});
    wr(CTRL_OFS, 32'h3);
    st = 1;
    repeat (2) @(negedge aclk);
    look();
    go(1);
    drop();
    go(0);
    go(0);
    go(2);
    go(1);
    go(1);
    go(0);
    drop();
    rm.feedback(1'b0);
    hv_wait(0, 3 * TC + 8);
    chk(hv_enable, 1'b0);
    hv_wait(1, 3000);
    chk(n, RETRY_OFF_S * TC);
    rm.feedback(1'b1);
    hv_wait(0, (RETRY_ON_S + 4) * TC);
    chk(hv_enable, 1'b1);
    rd(STATUS_OFS);
    chk(d[10:4], 7'h0);
    rm.feedback(1'b0);
    {k, n, h} = {32'h0, 32'h0, 1'b1};
    while (fan_request === 1'b1 && n < 70000) begin
      @(negedge aclk);
      if (hv_enable && !h) k++;
      h = hv_enable;
      n++;
    end
    chk(k, RETRY_CHECKS - 1);
    chk({hv_enable, fan_request}, 2'h0);
    k = 0;
    repeat (4 * TC) begin
      @(negedge aclk);
      if (ion_led !== h) k++;
      h = ion_led;
    end
    chk(k != 0, 1'b1);
    // clock enable low: blink and prescaler must freeze
    @(posedge aclk);
    ce <= 1'b0;
    @(negedge aclk);
    {k, h} = {32'h0, ion_led};
    repeat (4 * TC) begin
      @(negedge aclk);
      if (ion_led !== h) k++;
    end
    chk(k, 0);
    chk({hv_enable, fan_request}, 2'h0);
    @(posedge aclk);
    ce <= 1'b1;
    // forced switch clears protection, ionizer and fan back on
    go(3);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(negedge aclk);
    st = 0;
    rd(STATUS_OFS);
    chk(d[10:0], 11'h0);
    go(0);
    tally_and_finish();
  end
endmodule
bind ionizer_mode_controller ionizer_monitor ionizer_monitor_inst (.aclk, .aresetn, .supply_ok,
  .ion_cmd, .onoff_cmd, .off_timer_cmd, .fan_tap_sel, .hv_enable, .fan_request, .fan_tap,
  .vane_cool_rules, .ion_led, .power_led);
`default_nettype wire

// *** dv/ionizer_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module ionizer_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // supply and remote
  input wire logic supply_ok,
  input wire logic ion_cmd,
  input wire logic onoff_cmd,
  input wire logic off_timer_cmd,
  input wire logic [1:0] fan_tap_sel,
  // drives and indicators
  input wire logic hv_enable,
  input wire logic fan_request,
  input wire logic [1:0] fan_tap,
  input wire logic vane_cool_rules,
  input wire logic ion_led,
  input wire logic power_led
);
  logic [1:0] sup_q;
  logic sup_ok;
  logic c_ion;
  // commands count only once supply_ok has stayed high for three cycles
  always_ff @(posedge aclk) begin
    if (!aresetn || !supply_ok) begin
      sup_q <= 2'h0;
    end else if (sup_q != 2'h3) begin
      sup_q <= sup_q + 2'h1;
    end
  end
  assign sup_ok = (sup_q == 2'h3);
  assign c_ion = ion_cmd && !onoff_cmd && !off_timer_cmd;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // operating states as seen at the drives
  sequence s_only;
    sup_ok && fan_request && !power_led && hv_enable;
  endsequence
  sequence s_idle;
    sup_ok && !fan_request && !power_led && !hv_enable && !ion_led;
  endsequence
  sequence s_mode;
    sup_ok && power_led && hv_enable;
  endsequence
  AST_IDLE_ION: assert property (s_idle ##0 c_ion |=> hv_enable && fan_request && ion_led && !power_led)
    else $error("ion press in standby did not start fan and ionizer");
  AST_ONLY_ION_OFF: assert property (s_only ##0 c_ion |=> !hv_enable && !fan_request && !ion_led)
    else $error("ion press in ion-only did not return to standby");
  AST_ONLY_TAP: assert property (s_only ##0 !ion_cmd && !onoff_cmd && !off_timer_cmd |=> fan_tap == $past(fan_tap_sel))
    else $error("fan tap did not follow remote selection");
  AST_ONLY_VANE: assert property (sup_ok && fan_request && !power_led |-> vane_cool_rules)
    else $error("vane not under cooling rules in ion-only");
  AST_ONLY_ONOFF: assert property (s_only ##0 onoff_cmd |=> power_led && hv_enable && ion_led)
    else $error("on/off in ion-only did not keep ionizer in mode");
  AST_MODE_ION_ON: assert property (sup_ok && power_led && !hv_enable && !ion_led && c_ion |=> hv_enable && ion_led && power_led)
    else $error("ion press while running did not start ionizer");
  AST_MODE_ION_STOP: assert property (s_mode ##0 (onoff_cmd || off_timer_cmd || ion_cmd) |=> !hv_enable)
    else $error("ionizer kept running after stop command");
  AST_USER_ON_BARE: assert property (s_idle ##0 (onoff_cmd && !off_timer_cmd) |=> power_led && !hv_enable && !ion_led)
    else $error("user on started with ionizer");
  AST_LOSS_OFF: assert property ($fell(supply_ok) |-> ##[1:4] (!hv_enable && !fan_request && !power_led))
    else $error("drives stayed on after supply loss");
endmodule
`default_nettype wire

// *** dv/remote_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module remote_model (
  // clock
  input wire logic aclk,
  // receiver pulses
  output var logic ion_cmd,
  output var logic onoff_cmd,
  output var logic off_timer_cmd,
  output var logic forced_sw_cmd,
  // mains and feedback levels
  output var logic supply_ok,
  output var logic ion_fb_ok
);
  // receiver idle, mains present, feedback healthy
  initial begin
    {ion_cmd, onoff_cmd, off_timer_cmd, forced_sw_cmd} = 4'h0;
    supply_ok = 1'b1;
    ion_fb_ok = 1'b1;
  end
  // one-cycle pulse per key: 0 ion, 1 on/off, 2 off timer, 3 forced switch
  task automatic press(input int k);
    @(posedge aclk);
    ion_cmd <= (k == 0);
    onoff_cmd <= (k == 1);
    off_timer_cmd <= (k == 2);
    forced_sw_cmd <= (k == 3);
    @(posedge aclk);
    {ion_cmd, onoff_cmd, off_timer_cmd, forced_sw_cmd} <= 4'h0;
  endtask
  // levels change just after an edge
  task automatic mains(input logic v);
    @(posedge aclk);
    supply_ok <= v;
  endtask
  task automatic feedback(input logic v);
    @(posedge aclk);
    ion_fb_ok <= v;
  endtask
endmodule
`default_nettype wire

// *** verilog/ionizer_mode_controller.sv ***
`timescale 1ns/100ps
`default_nettype none
// How it works
// RL1: standby ion press: fan, ionizer, ion led
// RL2: ion press in ion-only returns standby
// RL3: ion-only fan follows remote tap or auto
// RL4: ion-only vane uses cooling rules, user honoured
// RL5: on/off in ion-only: mode plus ionizer
// RL6: ion-only resumes immediately after supply returns
// RL7: 24 failed checks: ionizer off, fan off in ion-only, blink
// RL8: ion press while running: ionizer, both leds
// RL9: on/off, timer off, ion, error stop ionizing
// RL10: ionizer choice forgotten after user off
// RL11: mode plus ionizer resumes after supply returns
// RL12: retry: 10 min off, then 10s on, 23 times
// RL13: count cleared: exhausted, cancelled, or feedback ok
// RL14: protection cleared: reset, on/off, forced, timer off
// RL15: restart ionizer only if running without protection
// RL16: retry intervals counted from one-second tick
module ionizer_mode_controller
  import ionizer_pkg::*;
#(
  parameter int TICK_CYCLES_P = ionizer_pkg::TICK_CYCLES
) (
  // clock, reset, clock enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // remote receiver command pulses and selection levels
  input wire logic ion_cmd,
  input wire logic onoff_cmd,
  input wire logic off_timer_cmd,
  input wire logic forced_sw_cmd,
  input wire logic [2:0] mode_sel,
  input wire logic fan_auto_sel,
  input wire logic [1:0] fan_tap_sel,
  // supply and feedback pins
  input wire logic supply_ok,
  input wire logic ion_fb_ok,
  // drives and indicators
  output logic hv_enable,
  output logic fan_request,
  output logic fan_auto,
  output logic [1:0] fan_tap,
  output logic vane_cool_rules,
  output logic [2:0] run_mode,
  output logic ion_led,
  output logic power_led,
  output logic irq
);
  //////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    op_state_t st;
    logic [2:0] mode;
    logic lock;
    logic retry;
    logic retry_on;
    logic [CNT_W-1:0] cnt;
    logic [SEC_W-1:0] sec;
    logic blink;
    logic down;
    logic restart;
    logic allow;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic aw_v;
    logic [3:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic w_s;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic hv;
    logic fan;
    logic fauto;
    logic [1:0] ftap;
    logic vane;
    logic iled;
    logic pled;
  } state_t;

  localparam logic [SEC_W-1:0] ON_LAST = SEC_W'(RETRY_ON_S - 1);
  localparam logic [SEC_W-1:0] OFF_LAST = SEC_W'(RETRY_OFF_S - 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RETRY_CHECKS);

  state_t q, d;
  logic tick;
  logic [1:0] pins_s;
  logic supply_s;
  logic fb_ok_s;

  initial begin
    if (RETRY_CHECKS >= (1 << CNT_W)) $error("retry count too wide");
    if (RETRY_OFF_S >= (1 << SEC_W)) $error("seconds counter too narrow");
  end

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers and the one-second prescaler
  level_sync #(.W(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .async_in({supply_ok, ion_fb_ok}),
    .sync_out(pins_s)
  );
  assign supply_s = pins_s[1];
  assign fb_ok_s = pins_s[0];

  second_tick #(.TICK_CYCLES(TICK_CYCLES_P)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .tick(tick)
  );

  // ionizer selected in the current state
  function automatic logic ion_sel(input op_state_t s);
    return (s == ST_ION_ONLY) || (s == ST_MODE_ION);
  endfunction

  // register address decode shared by reads and writes
  function automatic logic mapped(input logic [3:0] a);
    return (a == CTRL_OFS) || (a == STATUS_OFS) || (a == IRQ_STAT_OFS) ||
           (a == IRQ_MASK_OFS);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic ion_p;
    logic stop_err;
    logic wr;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    ion_p = 1'b0;
    stop_err = 1'b0;
    wr = 1'b0;
    ev = '0;
    clr = '0;
    d = q;
    // bus: hold address and data until both are here
    if (awvalid && !q.aw_v) begin
      d.aw_v = 1'b1;
      d.aw_a = awaddr;
    end
    if (wvalid && !q.w_v) begin
      d.w_v = 1'b1;
      d.w_d = wdata;
      d.w_s = wstrb[0];
    end
    if (q.aw_v && q.w_v && !q.bv) begin
      wr = q.w_s;
      d.aw_v = 1'b0;
      d.w_v = 1'b0;
      d.bv = 1'b1;
      d.br = mapped(q.aw_a) ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.bv && bready) d.bv = 1'b0;
    if (wr && q.aw_a == CTRL_OFS) begin
      d.allow = q.w_d[CTRL_ALLOW_BIT];
      ion_p = q.w_d[CTRL_SOFT_ION_BIT];
    end
    if (wr && q.aw_a == IRQ_STAT_OFS) clr = q.w_d[IRQ_W-1:0];
    if (wr && q.aw_a == IRQ_MASK_OFS) d.irq_mask = q.w_d[IRQ_W-1:0];
    // bus: reads answered one cycle after acceptance
    if (arvalid && !q.rv) begin
      d.rv = 1'b1;
      d.rr = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      d.rd = '0;
      case (araddr)
        CTRL_OFS: d.rd[CTRL_ALLOW_BIT] = q.allow;
        STATUS_OFS: begin
          d.rd[ST_STATE_LSB +: 2] = q.st;
          d.rd[ST_HV_BIT] = q.hv;
          d.rd[ST_FAN_BIT] = q.fan;
          d.rd[ST_RETRY_BIT] = q.retry;
          d.rd[ST_LOCK_BIT] = q.lock;
          d.rd[ST_CNT_LSB +: CNT_W] = q.cnt;
          d.rd[ST_MODE_LSB +: 3] = q.mode;
        end
        IRQ_STAT_OFS: d.rd[IRQ_W-1:0] = q.irq_stat;
        IRQ_MASK_OFS: d.rd[IRQ_W-1:0] = q.irq_mask;
        default: d.rd = '0;
      endcase
    end else if (q.rv && rready) begin
      d.rv = 1'b0;
    end
    ion_p = ion_p | ion_cmd;
    if (tick) d.blink = !q.blink;
    if (!supply_s) begin
      // supply lost: remember whether to restart, drop everything
      if (!q.down) begin
        d.down = 1'b1;
        d.restart = q.hv && !q.retry && !q.lock; // RL15
      end
    end else if (q.down) begin
      // supply back: resume state, ionizer only if it may restart
      d.down = 1'b0;
      if (!q.restart) begin // RL15
        if (q.st == ST_ION_ONLY) d.st = ST_STANDBY;
        if (q.st == ST_MODE_ION) d.st = ST_MODE_RUN;
      end // else RL6 RL11: state kept, ionizer and fan restart
    end else begin
      // user commands, on/off first
      if (onoff_cmd) begin
        d.lock = 1'b0; // RL14
        stop_err = 1'b1;
        case (q.st)
          ST_STANDBY: d.st = ST_MODE_RUN; // RL10
          ST_ION_ONLY: d.st = ST_MODE_ION; // RL5
          ST_MODE_ION: d.st = ST_STANDBY; // RL9
          ST_MODE_RUN: d.st = ST_STANDBY;
          default: d.st = ST_STANDBY;
        endcase
      end else if (off_timer_cmd) begin
        d.lock = 1'b0; // RL14
        stop_err = 1'b1;
        d.st = ST_STANDBY; // RL9
      end else if (ion_p) begin
        stop_err = 1'b1; // RL13
        case (q.st)
          ST_STANDBY: d.st = ST_ION_ONLY; // RL1
          ST_ION_ONLY: d.st = ST_STANDBY; // RL2
          ST_MODE_RUN: d.st = ST_MODE_ION; // RL8
          ST_MODE_ION: d.st = ST_MODE_RUN; // RL9
          default: d.st = ST_STANDBY;
        endcase
      end
      if (forced_sw_cmd) begin
        d.lock = 1'b0; // RL14
        stop_err = 1'b1;
      end
      if (d.st == ST_MODE_RUN || d.st == ST_MODE_ION) d.mode = mode_sel;
      // error detection and the timed retry sequence
      if (stop_err) begin
        d.retry = 1'b0;
        d.cnt = '0; // RL13
        d.sec = '0;
      end else if (tick && ion_sel(q.st) && !q.lock) begin // RL16
        if (!q.retry) begin
          if (q.hv && !fb_ok_s) begin
            d.retry = 1'b1; // RL9
            d.retry_on = 1'b0;
            d.sec = '0;
            d.cnt = CNT_W'(1);
            ev[EV_FB_ERR] = 1'b1;
          end
        end else if (q.retry_on) begin
          d.sec = q.sec + 1'b1;
          if (q.sec == ON_LAST) begin // RL12
            d.sec = '0;
            d.retry_on = 1'b0;
            if (fb_ok_s) begin
              d.retry = 1'b0; // RL13
              d.cnt = '0;
            end else if (q.cnt + 1'b1 == CNT_LAST) begin
              d.lock = 1'b1; // RL7
              d.retry = 1'b0;
              d.cnt = '0; // RL13
              ev[EV_LOCK] = 1'b1;
            end else begin
              d.cnt = q.cnt + 1'b1;
            end
          end
        end else begin
          d.sec = q.sec + 1'b1;
          if (q.sec == OFF_LAST) begin // RL12
            d.sec = '0;
            d.retry_on = 1'b1;
          end
        end
      end
      if (!ion_sel(d.st)) begin
        d.retry = 1'b0;
        d.cnt = '0; // RL13
      end
    end
    // drives and indicators, registered
    d.hv = supply_s && !d.down && ion_sel(d.st) && q.allow && !d.lock &&
           (!d.retry || d.retry_on); // RL1 RL8 RL12
    d.fan = supply_s && !d.down && ((d.st == ST_ION_ONLY && !d.lock) ||
            d.st == ST_MODE_RUN || d.st == ST_MODE_ION); // RL1 RL7
    d.fauto = fan_auto_sel; // RL3
    d.ftap = fan_tap_sel; // RL3
    d.vane = d.st == ST_ION_ONLY; // RL4
    d.iled = supply_s && !d.down && ion_sel(d.st) &&
             ((d.lock || d.retry) ? d.blink : 1'b1); // RL7
    d.pled = supply_s && !d.down &&
             (d.st == ST_MODE_RUN || d.st == ST_MODE_ION); // RL1 RL8
    ev[EV_ION_ON] = d.hv && !q.hv && !q.retry;
    ev[EV_ION_OFF] = !d.hv && q.hv && !d.retry;
    // sticky status, a new event beats a clear in the same cycle
    d.irq_stat = (q.irq_stat & ~clr) | ev;
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= ST_STANDBY;
      q.allow <= CTRL_ALLOW_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // bus handshakes and outputs
  assign awready = !q.aw_v;
  assign wready = !q.w_v;
  assign bvalid = q.bv;
  assign bresp = q.br;
  assign arready = !q.rv;
  assign rvalid = q.rv;
  assign rdata = q.rd;
  assign rresp = q.rr;
  assign hv_enable = q.hv;
  assign fan_request = q.fan;
  assign fan_auto = q.fauto;
  assign fan_tap = q.ftap;
  assign vane_cool_rules = q.vane;
  assign run_mode = q.mode;
  assign ion_led = q.iled;
  assign power_led = q.pled;
  assign irq = |(q.irq_stat & q.irq_mask);
endmodule
`default_nettype wire

// *** verilog/ionizer_pkg.sv ***
package ionizer_pkg;
  // one-second tick derived from the clock rate
  localparam longint CLK_PERIOD_NS = 50;
  localparam longint TICK_PERIOD_NS = 1000000000;
  localparam int TICK_CYCLES = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);
  // retry timing in seconds and the check budget
  localparam int RETRY_ON_S = 10;
  localparam int RETRY_OFF_MIN = 10;
  localparam int RETRY_OFF_S = RETRY_OFF_MIN * 60;
  localparam int RETRY_CHECKS = 24;
  localparam int SEC_W = 10;
  localparam int CNT_W = 5;
  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS = 4'hc;
  // control fields
  localparam int CTRL_ALLOW_BIT = 0;
  localparam int CTRL_SOFT_ION_BIT = 1;
  localparam logic CTRL_ALLOW_RST = 1'b1;
  // status fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_HV_BIT = 2;
  localparam int ST_FAN_BIT = 3;
  localparam int ST_RETRY_BIT = 4;
  localparam int ST_LOCK_BIT = 5;
  localparam int ST_CNT_LSB = 6;
  localparam int ST_MODE_LSB = 11;
  // interrupt event bits
  localparam int IRQ_W = 4;
  localparam int EV_ION_ON = 0;
  localparam int EV_ION_OFF = 1;
  localparam int EV_FB_ERR = 2;
  localparam int EV_LOCK = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // operating states, gray along standby, ion only, mode+ion, mode
  typedef enum logic [1:0] {
    ST_STANDBY = 2'h0,
    ST_ION_ONLY = 2'h1,
    ST_MODE_ION = 2'h3,
    ST_MODE_RUN = 2'h2
  } op_state_t;
endpackage

// *** verilog/level_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // async levels in, synced levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  initial begin
    if (W < 1) $error("level_sync width must be at least one");
  end

  // two flops; the first feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** verilog/second_tick.sv ***
`timescale 1ns/100ps
`default_nettype none
module second_tick #(
  parameter int TICK_CYCLES = 20000000
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // one-cycle pulse each tick period
  output logic tick
);
  localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
  logic [CW-1:0] cnt_q;

  initial begin
    if (TICK_CYCLES < 2) $error("tick period must be at least two cycles");
  end

  // free-running prescaler from the system clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= (cnt_q == LAST); // RL16
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule
`default_nettype wire
